// [src/clock_mode_pkg.sv]
/*
 * constants, types and port map for the dual clock mode controller.
 * assumes a 40 MHz controller clock and a 32.768 kHz slow crystal.
 */
package clock_mode_pkg;

    // controller clock rate and slow crystal rate
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned SLOW_OSC_HZ = 32_768;
    // divider giving one enable pulse per slow clock period
    localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;

    // port addresses, 5-bit port space
    localparam logic [4:0] STATUS_PORT_ADDR = 5'h0E;
    localparam logic [4:0] COMMAND_PORT_ADDR = 5'h16;

    // command port field positions
    localparam int unsigned CMD_SLOW_BIT = 2;
    localparam int unsigned CMD_WARMUP_LSB = 0;

    // status port field positions
    localparam int unsigned STAT_SLOW_BIT = 0;
    localparam int unsigned STAT_STABLE_BIT = 1;
    localparam int unsigned STAT_SERIAL_LSB = 2;

    // value returned for a read of a port with no readable data
    localparam logic [3:0] UNDEFINED_READ = 4'h0;

    // warm-up times in microseconds, per warmup_select code
    localparam int unsigned WARMUP_US_0 = 7_800;
    localparam int unsigned WARMUP_US_1 = 7_800;
    localparam int unsigned WARMUP_US_2 = 31_250;
    localparam int unsigned WARMUP_US_3 = 125_000;
    // least times, so counts round up to whole slow periods
    localparam int unsigned WARMUP_TICKS_0 = 32'((WARMUP_US_0 * 64'(SLOW_OSC_HZ) + 999_999) / 1_000_000);
    localparam int unsigned WARMUP_TICKS_1 = 32'((WARMUP_US_1 * 64'(SLOW_OSC_HZ) + 999_999) / 1_000_000);
    localparam int unsigned WARMUP_TICKS_2 = 32'((WARMUP_US_2 * 64'(SLOW_OSC_HZ) + 999_999) / 1_000_000);
    localparam int unsigned WARMUP_TICKS_3 = 32'((WARMUP_US_3 * 64'(SLOW_OSC_HZ) + 999_999) / 1_000_000);
    // width of the warm-up tick counter
    localparam int unsigned WARMUP_CNT_W = 13;

    // operating states of the controller
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_SLOW,
        MODE_WARMUP
    } mode_state_type;

    // one port instruction from the core, same clock domain
    typedef struct packed {
        logic [4:0] addr;
        logic wr;
        logic rd;
        logic [3:0] data;
    } port_access_type;

    // clock steering and unit gating outputs
    typedef struct packed {
        logic fast_osc_run;
        logic clk_sel_slow;
        logic slow_mode;
        logic rate_4096_off;
        logic serial_enable;
        logic display_enable;
    } clock_ctrl_type;

endpackage

// [src/dual_clock_mode_controller.sv]
/*
 * dual clock mode controller: normal / slow mode selection, fast
 * oscillator stop, warm-up timing on return, command and status ports.
 * assumes port accesses come as one-cycle strobes on i_clk, and that
 * the slow oscillator stable level arrives asynchronously.
 */
`timescale 1ns/1ps

module dual_clock_mode_controller #(
    parameter int unsigned SLOW_DIV = clock_mode_pkg::SLOW_DIV
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire clock_mode_pkg::port_access_type i_port,
    input wire logic i_slow_osc_stable,
    input wire logic [1:0] i_serial_status,
    output logic [3:0] o_in_data,
    output logic o_fast_osc_run,
    output logic o_clk_sel_slow,
    output logic o_slow_mode,
    output logic o_rate_4096_off,
    output logic o_serial_enable,
    output logic o_display_enable
);

    // synchroniser stages for the slow oscillator stable level
    logic stable_meta_q;
    logic stable_q;

    // slow period divider
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic slow_tick_q;
    logic slow_tick_d;

    // mode state and warm-up counter
    clock_mode_pkg::mode_state_type state_q;
    clock_mode_pkg::mode_state_type state_d;
    logic [clock_mode_pkg::WARMUP_CNT_W-1:0] cnt_q;
    logic [clock_mode_pkg::WARMUP_CNT_W-1:0] cnt_d;

    // registered outputs
    clock_mode_pkg::clock_ctrl_type ctrl_q;
    clock_mode_pkg::clock_ctrl_type ctrl_d;
    logic [3:0] in_data_q;
    logic [3:0] in_data_d;

    // decoded port instructions
    logic cmd_write;
    logic status_read;
    logic cmd_read;

    // warm-up length picked by the command
    logic [clock_mode_pkg::WARMUP_CNT_W-1:0] warmup_len;

    // two flip-flops before the stable level is used
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            stable_meta_q <= 1'b0;
            stable_q <= 1'b0;
        end
        else
        begin
            stable_meta_q <= i_slow_osc_stable;
            stable_q <= stable_meta_q;
        end
    end

    // divider: one pulse per slow oscillator period
    always_comb
    begin
        // wrap at the last count, pulse on the wrap
        if (div_q == 16'(SLOW_DIV - 1))
        begin
            div_d = 16'h0000;
            slow_tick_d = 1'b1;
        end
        else
        begin
            div_d = div_q + 16'h0001;
            slow_tick_d = 1'b0;
        end
    end

    // divider registers
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_q <= 16'h0000;
            slow_tick_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            slow_tick_q <= slow_tick_d;
        end
    end

    // port decode
    // command and status ports
    assign cmd_write = i_port.wr && (i_port.addr == clock_mode_pkg::COMMAND_PORT_ADDR);
    assign status_read = i_port.rd && (i_port.addr == clock_mode_pkg::STATUS_PORT_ADDR);
    assign cmd_read = i_port.rd && (i_port.addr == clock_mode_pkg::COMMAND_PORT_ADDR);

    // warm-up length lookup
    always_comb
    begin
        case (i_port.data[clock_mode_pkg::CMD_WARMUP_LSB +: 2])
            2'b00: warmup_len = clock_mode_pkg::WARMUP_CNT_W'(clock_mode_pkg::WARMUP_TICKS_0);
            2'b01: warmup_len = clock_mode_pkg::WARMUP_CNT_W'(clock_mode_pkg::WARMUP_TICKS_1);
            2'b10: warmup_len = clock_mode_pkg::WARMUP_CNT_W'(clock_mode_pkg::WARMUP_TICKS_2);
            default: warmup_len = clock_mode_pkg::WARMUP_CNT_W'(clock_mode_pkg::WARMUP_TICKS_3);
        endcase
    end

    // mode state machine
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            // fast clock drives the system
            clock_mode_pkg::MODE_NORMAL:
            begin
                if (cmd_write && i_port.data[clock_mode_pkg::CMD_SLOW_BIT])
                begin
                    state_d = clock_mode_pkg::MODE_SLOW;
                end
            end
            // fast oscillator halted
            clock_mode_pkg::MODE_SLOW:
            begin
                if (cmd_write && !i_port.data[clock_mode_pkg::CMD_SLOW_BIT])
                begin
                    state_d = clock_mode_pkg::MODE_WARMUP;
                    cnt_d = warmup_len;
                end
            end
            // fast oscillator restarting, still on slow clock
            clock_mode_pkg::MODE_WARMUP:
            begin
                if (cmd_write && i_port.data[clock_mode_pkg::CMD_SLOW_BIT])
                begin
                    // re-request of slow aborts the warm-up
                    state_d = clock_mode_pkg::MODE_SLOW;
                end
                else if (slow_tick_q)
                begin
                    if (cnt_q <= clock_mode_pkg::WARMUP_CNT_W'(1))
                    begin
                        state_d = clock_mode_pkg::MODE_NORMAL;
                        cnt_d = '0;
                    end
                    else
                    begin
                        cnt_d = cnt_q - clock_mode_pkg::WARMUP_CNT_W'(1);
                    end
                end
            end
            default:
            begin
                state_d = clock_mode_pkg::MODE_NORMAL;
                cnt_d = '0;
            end
        endcase
    end

    // mode registers
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= clock_mode_pkg::MODE_NORMAL;
            cnt_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // clock steering and unit gating, from the next state
    always_comb
    begin
        ctrl_d.fast_osc_run = (state_d != clock_mode_pkg::MODE_SLOW);
        ctrl_d.clk_sel_slow = (state_d != clock_mode_pkg::MODE_NORMAL);
        ctrl_d.slow_mode = (state_d != clock_mode_pkg::MODE_NORMAL);
        ctrl_d.rate_4096_off = (state_d != clock_mode_pkg::MODE_NORMAL);
        ctrl_d.serial_enable = (state_d == clock_mode_pkg::MODE_NORMAL);
        ctrl_d.display_enable = (state_d == clock_mode_pkg::MODE_NORMAL);
    end

    // read data for input instructions
    always_comb
    begin
        in_data_d = clock_mode_pkg::UNDEFINED_READ;
        if (status_read)
        begin
            in_data_d[clock_mode_pkg::STAT_SLOW_BIT] = ctrl_q.slow_mode;
            in_data_d[clock_mode_pkg::STAT_STABLE_BIT] = stable_q;
            in_data_d[clock_mode_pkg::STAT_SERIAL_LSB +: 2] = i_serial_status;
        end
        else if (cmd_read)
        begin
            // write-only port answers the undefined value
            in_data_d = clock_mode_pkg::UNDEFINED_READ;
        end
    end

    // output registers, normal at power up
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_q <= '{fast_osc_run: 1'b1, clk_sel_slow: 1'b0, slow_mode: 1'b0,
                        rate_4096_off: 1'b0, serial_enable: 1'b1, display_enable: 1'b1};
            in_data_q <= 4'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            in_data_q <= in_data_d;
        end
    end

    // outputs straight from flops
    assign o_in_data = in_data_q;
    assign o_fast_osc_run = ctrl_q.fast_osc_run;
    assign o_clk_sel_slow = ctrl_q.clk_sel_slow;
    assign o_slow_mode = ctrl_q.slow_mode;
    assign o_rate_4096_off = ctrl_q.rate_4096_off;
    assign o_serial_enable = ctrl_q.serial_enable;
    assign o_display_enable = ctrl_q.display_enable;

    // checks, all on i_clk and gated by reset
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // a slow request written from normal mode
    sequence slow_req_s;
        cmd_write && i_port.data[clock_mode_pkg::CMD_SLOW_BIT] && state_q == clock_mode_pkg::MODE_NORMAL;
    endsequence

    // a return request written from slow mode
    sequence return_req_s;
        cmd_write && !i_port.data[clock_mode_pkg::CMD_SLOW_BIT] && state_q == clock_mode_pkg::MODE_SLOW;
    endsequence

    chk_slow_entry: assert property (slow_req_s |=> o_slow_mode && !o_fast_osc_run)
        else $error("slow request did not stop the fast oscillator");

    chk_warm_start: assert property (return_req_s |=> o_fast_osc_run && o_clk_sel_slow && o_slow_mode)
        else $error("return request did not start warm-up on slow clock");

    // slow clock kept on warm-up cycles without a tick or a command write
    chk_warm_hold: assert property ((state_q == clock_mode_pkg::MODE_WARMUP && !slow_tick_q && !cmd_write)
        |=> o_clk_sel_slow)
        else $error("warm-up left before its period elapsed");

    chk_warm_done: assert property ((state_q == clock_mode_pkg::MODE_WARMUP && slow_tick_q && !cmd_write
        && cnt_q == clock_mode_pkg::WARMUP_CNT_W'(1)) |=> !o_clk_sel_slow && !o_slow_mode)
        else $error("warm-up end did not return to normal mode");

    chk_flag_mode: assert property (status_read |=> o_in_data[clock_mode_pkg::STAT_SLOW_BIT] == $past(o_slow_mode))
        else $error("status bit 0 does not follow the mode");

    chk_flag_stable: assert property (status_read |=> o_in_data[clock_mode_pkg::STAT_STABLE_BIT] == $past(stable_q))
        else $error("status bit 1 does not follow slow stability");

    chk_gate_units: assert property (o_slow_mode |-> o_rate_4096_off && !o_serial_enable && !o_display_enable)
        else $error("fast-only units left enabled in slow mode");

    // read of the command port changes nothing
    chk_cmd_read: assert property ((cmd_read && state_q != clock_mode_pkg::MODE_WARMUP)
        |=> $stable(state_q) && o_in_data == clock_mode_pkg::UNDEFINED_READ)
        else $error("command port read had an effect");

    // writes to the status port do nothing
    chk_status_wr: assert property ((i_port.wr && i_port.addr == clock_mode_pkg::STATUS_PORT_ADDR
        && state_q == clock_mode_pkg::MODE_NORMAL) |=> !o_slow_mode)
        else $error("status port write changed the mode");

    chk_two_modes: assert property (o_clk_sel_slow == o_slow_mode)
        else $error("clock source and mode flag disagree");

endmodule

// [test/core_port_model.sv]
/*
 * partner model: the core program issuing port input and output
 * instructions to the clock mode controller.
 * assumes each instruction is held for one clock, with an idle clock between, changed 2 ns after the rising edge.
 */
`timescale 1ns/1ps

module core_port_model (
    input wire logic i_clk,
    input wire logic [3:0] i_in_data,
    output clock_mode_pkg::port_access_type o_port
);
    // idle bus from time zero
    initial o_port = '0;

    // one port instruction held over a single taking edge
    task automatic port_op(input logic [4:0] addr, input logic wr, input logic [3:0] data, output logic [3:0] rdata);
        @(posedge i_clk);
        #2;
        o_port.addr = addr;
        o_port.wr = wr;
        o_port.rd = ~wr;
        o_port.data = data;
        @(posedge i_clk);
        #2;
        rdata = i_in_data;
        o_port = '0;
    endtask

    // idle slot after entry
    // one no-operation cycle, no strobe
    task automatic nop();
        @(posedge i_clk);
        #2;
    endtask

    // slow request
    // pattern 0100 then the required no-operation
    task automatic slow_request();
        logic [3:0] unused;
        port_op(clock_mode_pkg::COMMAND_PORT_ADDR, 1'b1, 4'h4, unused);
        nop();
    endtask

    // return request
    // bit 2 cleared, warm-up select in the same write
    task automatic normal_request(input logic [1:0] sel);
        logic [3:0] unused;
        port_op(clock_mode_pkg::COMMAND_PORT_ADDR, 1'b1, {2'b00, sel}, unused);
    endtask
endmodule

// [test/tb_top.sv]
/*
 * self-checking testbench for the dual clock mode controller.
 * assumes the core port model for port instructions and a small
 * slow divider so warm-up spans stay short.
 */
`timescale 1ns/1ps

module tb_top;
    localparam int unsigned DIV = 4; // shortened slow period
    logic i_clk = 1'b0; // 40 mhz clock
    logic i_rst = 1'b1; // async reset
    logic i_slow_osc_stable = 1'b0; // slow crystal settled
    logic [1:0] i_serial_status = 2'b10; // serial unit status
    clock_mode_pkg::port_access_type i_port; // port strobes
    logic [3:0] o_in_data; // read data
    logic o_fast_osc_run, o_clk_sel_slow, o_slow_mode; // mode levels
    logic o_rate_4096_off, o_serial_enable, o_display_enable; // unit gates
    int miscompares = 0; // mismatch count
    int checked = 0; // comparison count
    logic [3:0] rd; // value read back
    int unsigned ticks [4] = '{256, 256, 1024, 4096}; // warm-up periods per code
    int k; // edges waited

    always #12.5 i_clk = ~i_clk;

    dual_clock_mode_controller #(.SLOW_DIV(DIV)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_port(i_port),
        .i_slow_osc_stable(i_slow_osc_stable), .i_serial_status(i_serial_status), .o_in_data(o_in_data),
        .o_fast_osc_run(o_fast_osc_run), .o_clk_sel_slow(o_clk_sel_slow), .o_slow_mode(o_slow_mode),
        .o_rate_4096_off(o_rate_4096_off), .o_serial_enable(o_serial_enable),
        .o_display_enable(o_display_enable));

    core_port_model core_u (.i_clk(i_clk), .i_in_data(o_in_data), .o_port(i_port));

    // compare and count
    task automatic check(input string name, input logic [5:0] seen, input logic [5:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // all six mode levels as one word
    function automatic logic [5:0] levels();
        return {o_fast_osc_run, o_clk_sel_slow, o_slow_mode, o_rate_4096_off, o_serial_enable, o_display_enable};
    endfunction

    // verdict and end of run
    task automatic complete_run();
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog well beyond the longest warm-up
    initial
    begin
        #(25 * 40000);
        miscompares++;
        complete_run();
    end

    initial
    begin
        repeat (3) @(posedge i_clk);
        #2;
        i_rst = 1'b0;
        check("reset levels", levels(), 6'h23);
        core_u.port_op(5'h0E, 1'b0, 4'h0, rd);
        check("status unstable", {2'b00, rd}, 6'h08);
        i_slow_osc_stable = 1'b1;
        repeat (4) @(posedge i_clk);
        core_u.port_op(5'h0E, 1'b0, 4'h0, rd);
        check("status stable", {2'b00, rd}, 6'h0A);
        core_u.port_op(5'h16, 1'b0, 4'h0, rd);
        check("command read", {2'b00, rd}, 6'h00);
        core_u.port_op(5'h0E, 1'b1, 4'h4, rd);
        core_u.normal_request(2'b01);
        check("no mode change", levels(), 6'h23);
        for (int c = 0; c < 4; c++)
        begin
            core_u.slow_request();
            check("slow levels", levels(), 6'h1C);
            core_u.port_op(5'h0E, 1'b0, 4'h0, rd);
            check("status slow", {2'b00, rd}, 6'h0B);
            core_u.normal_request(c[1:0]);
            check("warm-up levels", levels(), 6'h3C);
            k = 0;
            while (o_clk_sel_slow === 1'b1 && k < 20000)
            begin
                @(posedge i_clk);
                #2;
                k++;
            end
            check("warm-up span", {5'h00, k >= (ticks[c] - 1) * DIV + 1 && k <= ticks[c] * DIV + 1}, 6'h01);
            check("normal levels", levels(), 6'h23);
        end
        core_u.slow_request();
        core_u.normal_request(2'b10);
        repeat (3) @(posedge i_clk);
        core_u.slow_request();
        check("warm-up abort", levels(), 6'h1C);
        i_rst = 1'b1;
        #1;
        check("reset in slow", levels(), 6'h23);
        @(posedge i_clk);
        #2;
        i_rst = 1'b0;
        core_u.slow_request();
        check("slow after reset", levels(), 6'h1C);
        complete_run();
    end
endmodule
